// >>> asr_top.sv
// serial rate and format block: wishbone registers, transmitter and receiver
//
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`include "asr_cfg.svh"
`default_nettype none
module asr_top
	import asr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	input wire logic serial_in_pin_i,
	output logic serial_out_pin_o,
	output logic serial_out_pin_oe_o,
	output logic irq_o
);
	// software-visible control
	logic [2:0] serial_mode_sel_q;
	logic stop_len_sel_q;
	logic parity_on_q;
	logic parity_odd_q;
	logic [7:0] baud_divider_q;
	logic div8_source_q;
	logic clk_edge_sel_q;
	logic bit_order_sel_q;
	logic open_drain_q;
	logic tx_on_q;
	logic rx_on_q;
	logic tx_block_q;
	logic [8:0] tx_buffer_q;
	logic tx_full_q;
	logic [8:0] rx_buffer_q;
	logic rx_full_q;

	// bus strobes
	logic req;
	logic wr;
	logic rd;
	logic wr_mode;
	logic wr_baud;
	logic wr_ctla;
	logic wr_ctlb;
	logic wr_txb;
	logic rd_rxb;
	logic [31:0] rd_d;

	// datapath state
	asr_fmt_t fmt;
	logic uart_on;
	logic tick16;
	logic tx_run;
	logic tx_load;
	logic tx_wrap;
	logic tx_done;
	asr_st_t tx_st_q;
	logic [3:0] tx_ph_q;
	logic [3:0] tx_n_q;
	logic tx_sc_q;
	logic [8:0] tx_sh_q;
	logic tx_bit_q;
	logic out_upd;
	logic rx_run;
	logic rx_smp;
	logic rx_done;
	asr_st_t rx_st_q;
	logic [3:0] rx_ph_q;
	logic [3:0] rx_n_q;
	logic rx_sc_q;
	logic [8:0] rx_sh_q;
	logic rx_perr_q;
	logic [`ASR_ST_W-1:0] ev;
	logic [`ASR_ST_W-1:0] stat;
	logic [`ASR_ST_W-1:0] mask;

	assign req = cyc_i & stb_i & ~ack_o;
	assign wr = req & we_i & sel_i[0];
	assign rd = req & ~we_i;

	// plain address compare; unmapped offsets still ack and read zero
	assign wr_mode = wr && (adr_i == `ASR_OFS_MODE);
	assign wr_baud = wr && (adr_i == `ASR_OFS_BAUD);
	assign wr_ctla = wr && (adr_i == `ASR_OFS_CTLA);
	assign wr_ctlb = wr && (adr_i == `ASR_OFS_CTLB);
	assign wr_txb = wr && (adr_i == `ASR_OFS_TXB);
	assign rd_rxb = rd && (adr_i == `ASR_OFS_RXB);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= req;
		end
	end

	always_comb begin
		rd_d = 32'h0000_0000;
		if (adr_i == `ASR_OFS_MODE) begin
			rd_d = {26'h0, parity_odd_q, parity_on_q, stop_len_sel_q, serial_mode_sel_q};
		end else if (adr_i == `ASR_OFS_BAUD) begin
			rd_d = {24'h0, baud_divider_q};
		end else if (adr_i == `ASR_OFS_CTLA) begin
			rd_d = {28'h0, open_drain_q, bit_order_sel_q, clk_edge_sel_q, div8_source_q};
		end else if (adr_i == `ASR_OFS_CTLB) begin
			rd_d = {30'h0, rx_on_q, tx_on_q};
		end else if (adr_i == `ASR_OFS_TXB) begin
			rd_d = {23'h0, tx_buffer_q};
		end else if (adr_i == `ASR_OFS_RXB) begin
			rd_d = {23'h0, rx_buffer_q};
		end else if (adr_i == `ASR_OFS_STAT) begin
			rd_d = {26'h0, stat};
		end else if (adr_i == `ASR_OFS_MASK) begin
			rd_d = {26'h0, mask};
		end else if (adr_i == `ASR_OFS_STATE) begin
			rd_d = {27'h0, tx_block_q, rx_st_q != ASR_IDLE, rx_full_q, tx_full_q,
				tx_st_q != ASR_IDLE};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (rd) begin
			dat_o <= rd_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			serial_mode_sel_q <= `ASR_SMD_OFF;
			stop_len_sel_q <= 1'b0;
			parity_on_q <= 1'b0;
			parity_odd_q <= 1'b0;
		end else if (wr_mode) begin
			serial_mode_sel_q <= dat_i[2:0];
			stop_len_sel_q <= dat_i[`ASR_MODE_STOP2];
			parity_on_q <= dat_i[`ASR_MODE_PAR];
			parity_odd_q <= dat_i[`ASR_MODE_ODD];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			baud_divider_q <= `ASR_BAUD_RST;
		end else if (wr_baud) begin
			baud_divider_q <= dat_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div8_source_q <= 1'b0;
			clk_edge_sel_q <= 1'b0;
			bit_order_sel_q <= 1'b0;
			open_drain_q <= 1'b0;
		end else if (wr_ctla) begin
			div8_source_q <= dat_i[`ASR_CTLA_DIV8];
			clk_edge_sel_q <= dat_i[`ASR_CTLA_EDGE];
			bit_order_sel_q <= dat_i[`ASR_CTLA_ORDER];
			open_drain_q <= dat_i[`ASR_CTLA_OD];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_on_q <= 1'b0;
			rx_on_q <= 1'b0;
		end else if (wr_ctlb) begin
			tx_on_q <= dat_i[`ASR_CTLB_TX];
			rx_on_q <= dat_i[`ASR_CTLB_RX];
		end
	end

	// disabling the mode parks the transmitter until tx_on is written with one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_block_q <= 1'b0;
		end else if (wr_mode && dat_i[2:0] == `ASR_SMD_OFF) begin
			tx_block_q <= 1'b1;
		end else if (wr_ctlb && dat_i[`ASR_CTLB_TX]) begin
			tx_block_q <= 1'b0;
		end
	end

	assign uart_on = asr_is_uart(serial_mode_sel_q);

	assign fmt.nbits = asr_len(serial_mode_sel_q);
	assign fmt.par_on = parity_on_q;
	assign fmt.par_odd = parity_odd_q;
	assign fmt.msb = bit_order_sel_q && (fmt.nbits == `ASR_LEN8);
	assign fmt.stop2 = stop_len_sel_q;

	asr_baud u_baud (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(uart_on),
		.div8_i(div8_source_q),
		.div_i(baud_divider_q),
		.tick16_o(tick16)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_buffer_q <= 9'h000;
		end else if (wr_txb) begin
			tx_buffer_q <= {dat_i[8] & sel_i[1], dat_i[7:0]};
		end
	end

	// a buffer write in the load cycle is kept: set wins over the load
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_full_q <= 1'b0;
		end else if (!uart_on) begin
			tx_full_q <= 1'b0;
		end else if (wr_txb) begin
			tx_full_q <= 1'b1;
		end else if (tx_load) begin
			tx_full_q <= 1'b0;
		end
	end

	assign tx_run = tx_on_q & ~tx_block_q & uart_on;
	assign tx_load = (tx_st_q == ASR_IDLE) && tx_full_q && tx_run && tick16;
	assign tx_wrap = tick16 && (tx_ph_q == `ASR_PH_LAST);
	assign tx_done = tx_wrap && (tx_st_q == ASR_STOP) && !(fmt.stop2 && !tx_sc_q);

	// a frame under way finishes even if tx_on drops
	always_ff @(posedge clk_i) begin
		if (rst_i || !uart_on) begin
			tx_st_q <= ASR_IDLE;
			tx_ph_q <= 4'h0;
			tx_n_q <= 4'h0;
			tx_sc_q <= 1'b0;
			tx_sh_q <= 9'h000;
			tx_bit_q <= 1'b1;
		end else if (tx_load) begin
			tx_st_q <= ASR_START;
			tx_ph_q <= 4'h0;
			tx_sh_q <= tx_buffer_q;
			tx_bit_q <= 1'b0;
		end else if (tick16 && tx_st_q != ASR_IDLE) begin
			tx_ph_q <= 4'(tx_ph_q + 4'h1);
			if (tx_ph_q == `ASR_PH_LAST) begin
				case (tx_st_q)
					ASR_START: begin
						tx_st_q <= ASR_DATA;
						tx_n_q <= 4'h0;
						tx_bit_q <= tx_sh_q[asr_idx(fmt, 4'h0)];
					end
					ASR_DATA: begin
						if (tx_n_q == 4'(fmt.nbits - 4'h1)) begin
							if (fmt.par_on) begin
								tx_st_q <= ASR_PAR;
								tx_bit_q <= asr_par(tx_sh_q, fmt);
							end else begin
								tx_st_q <= ASR_STOP;
								tx_sc_q <= 1'b0;
								tx_bit_q <= 1'b1;
							end
						end else begin
							tx_n_q <= 4'(tx_n_q + 4'h1);
							tx_bit_q <= tx_sh_q[asr_idx(fmt, 4'(tx_n_q + 4'h1))];
						end
					end
					ASR_PAR: begin
						tx_st_q <= ASR_STOP;
						tx_sc_q <= 1'b0;
						tx_bit_q <= 1'b1;
					end
					ASR_STOP: begin
						if (fmt.stop2 && !tx_sc_q) begin
							tx_sc_q <= 1'b1;
						end else begin
							tx_st_q <= ASR_IDLE;
						end
					end
					default: begin
						tx_st_q <= ASR_IDLE;
					end
				endcase
			end
		end
	end

	// edge 0: line follows the bit boundary; edge 1: launch half a bit later
	assign out_upd = !clk_edge_sel_q || (tx_st_q == ASR_IDLE) ||
		(tick16 && tx_ph_q == `ASR_PH_MID);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			serial_out_pin_o <= 1'b1;
			serial_out_pin_oe_o <= 1'b1;
		end else if (out_upd) begin
			serial_out_pin_o <= tx_bit_q;
			serial_out_pin_oe_o <= open_drain_q ? !tx_bit_q : 1'b1;
		end else begin
			serial_out_pin_oe_o <= open_drain_q ? !serial_out_pin_o : 1'b1;
		end
	end

	assign rx_run = rx_on_q & uart_on;
	assign rx_smp = tick16 && (rx_ph_q == `ASR_PH_MID);
	assign rx_done = rx_smp && (rx_st_q == ASR_STOP) &&
		!(fmt.stop2 && !rx_sc_q && serial_in_pin_i);

	// dropping rx_on abandons the frame; mid-bit sampling of sixteen ticks
	always_ff @(posedge clk_i) begin
		if (rst_i || !rx_run) begin
			rx_st_q <= ASR_IDLE;
			rx_ph_q <= 4'h0;
			rx_n_q <= 4'h0;
			rx_sc_q <= 1'b0;
			rx_sh_q <= 9'h000;
			rx_perr_q <= 1'b0;
		end else if (rx_st_q == ASR_IDLE) begin
			if (tick16 && !serial_in_pin_i) begin
				rx_st_q <= ASR_START;
				rx_ph_q <= 4'h0;
			end
		end else if (tick16) begin
			rx_ph_q <= 4'(rx_ph_q + 4'h1);
			if (rx_ph_q == `ASR_PH_MID) begin
				case (rx_st_q)
					ASR_START: begin
						if (serial_in_pin_i) begin
							rx_st_q <= ASR_IDLE;
						end else begin
							rx_st_q <= ASR_DATA;
							rx_n_q <= 4'h0;
							rx_perr_q <= 1'b0;
						end
					end
					ASR_DATA: begin
						rx_sh_q[asr_idx(fmt, rx_n_q)] <= serial_in_pin_i;
						if (rx_n_q == 4'(fmt.nbits - 4'h1)) begin
							rx_st_q <= fmt.par_on ? ASR_PAR : ASR_STOP;
							rx_sc_q <= 1'b0;
						end else begin
							rx_n_q <= 4'(rx_n_q + 4'h1);
						end
					end
					ASR_PAR: begin
						rx_perr_q <= serial_in_pin_i ^ asr_par(rx_sh_q, fmt);
						rx_st_q <= ASR_STOP;
						rx_sc_q <= 1'b0;
					end
					ASR_STOP: begin
						if (fmt.stop2 && !rx_sc_q && serial_in_pin_i) begin
							rx_sc_q <= 1'b1;
						end else begin
							rx_st_q <= ASR_IDLE;
						end
					end
					default: begin
						rx_st_q <= ASR_IDLE;
					end
				endcase
			end
		end
	end

	// bits above the character length carry leftovers, not zeros
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_buffer_q <= 9'h000;
		end else if (!rx_on_q) begin
			rx_buffer_q <= 9'h000;
		end else if (rx_done) begin
			rx_buffer_q <= rx_sh_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_full_q <= 1'b0;
		end else if (rx_done) begin
			rx_full_q <= 1'b1;
		end else if (!rx_on_q || rd_rxb) begin
			rx_full_q <= 1'b0;
		end
	end

	assign ev[`ASR_ST_TXE] = tx_load;
	assign ev[`ASR_ST_TXD] = tx_done;
	assign ev[`ASR_ST_RXF] = rx_done;
	assign ev[`ASR_ST_OVR] = rx_done && rx_full_q && !rd_rxb;
	assign ev[`ASR_ST_PER] = rx_done && fmt.par_on && rx_perr_q;
	assign ev[`ASR_ST_FER] = rx_done && !serial_in_pin_i;

	asr_irq u_irq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ev_i(ev),
		.clr_we_i(wr && (adr_i == `ASR_OFS_STAT)),
		.mask_we_i(wr && (adr_i == `ASR_OFS_MASK)),
		.wdat_i(dat_i[`ASR_ST_W-1:0]),
		.stat_o(stat),
		.mask_o(mask),
		.irq_o(irq_o)
	);
endmodule : asr_top
`default_nettype wire

// >>> asr_cfg.svh
// register map, field positions, reset values and counts for the serial rate and format block
// Function
// - bit rate is source over divider over sixteen
// - source is undivided or divided-by-eight clock
// - rx_on off then on clears receive buffer
// - mode off then uart mode clears transmit buffer
// - three uart mode encodings re-enter async operation
// - writing tx_on one restarts transmission after recovery
// - bit order applies to 8-bit characters only
// - order zero: start, D0..D7, parity, stop
// - order one: start, D7..D0, parity, stop
// - tx changes on falling, rx samples rising
// - buffer uses low 7/8/9 bits, rest undefined
// - serial output idles high from mode select
`ifndef ASR_CFG_SVH
`define ASR_CFG_SVH
`define ASR_OFS_MODE 8'h00
`define ASR_OFS_BAUD 8'h04
`define ASR_OFS_CTLA 8'h08
`define ASR_OFS_CTLB 8'h0C
`define ASR_OFS_TXB 8'h10
`define ASR_OFS_RXB 8'h14
`define ASR_OFS_STAT 8'h18
`define ASR_OFS_MASK 8'h1C
`define ASR_OFS_STATE 8'h20
`define ASR_SMD_OFF 3'h0
`define ASR_SMD_U7 3'h1
`define ASR_SMD_U8 3'h5
`define ASR_SMD_U9 3'h6
`define ASR_LEN7 4'h7
`define ASR_LEN8 4'h8
`define ASR_LEN9 4'h9
`define ASR_MODE_STOP2 3
`define ASR_MODE_PAR 4
`define ASR_MODE_ODD 5
`define ASR_CTLA_DIV8 0
`define ASR_CTLA_EDGE 1
`define ASR_CTLA_ORDER 2
`define ASR_CTLA_OD 3
`define ASR_CTLB_TX 0
`define ASR_CTLB_RX 1
`define ASR_ST_TXE 0
`define ASR_ST_TXD 1
`define ASR_ST_RXF 2
`define ASR_ST_OVR 3
`define ASR_ST_PER 4
`define ASR_ST_FER 5
`define ASR_ST_W 6
`define ASR_BAUD_RST 8'h00
`define ASR_PRE_LAST 3'h7
`define ASR_PH_LAST 4'hF
`define ASR_PH_MID 4'h7
`endif

// >>> asr_pkg.sv
// shared types and helper functions for the serial rate and format block
`include "asr_cfg.svh"
`default_nettype none
package asr_pkg;
	typedef struct packed {
		logic [3:0] nbits;
		logic par_on;
		logic par_odd;
		logic msb;
		logic stop2;
	} asr_fmt_t;

	typedef enum logic [4:0] {
		ASR_IDLE = 5'h01,
		ASR_START = 5'h02,
		ASR_DATA = 5'h04,
		ASR_PAR = 5'h08,
		ASR_STOP = 5'h10
	} asr_st_t;

	function automatic logic asr_is_uart(input logic [2:0] m);
		return (m == `ASR_SMD_U7) || (m == `ASR_SMD_U8) || (m == `ASR_SMD_U9);
	endfunction : asr_is_uart

	function automatic logic [3:0] asr_len(input logic [2:0] m);
		return (m == `ASR_SMD_U7) ? `ASR_LEN7 : (m == `ASR_SMD_U9) ? `ASR_LEN9 : `ASR_LEN8;
	endfunction : asr_len

	// position in the character of the n-th bit on the line
	function automatic logic [3:0] asr_idx(input asr_fmt_t f, input logic [3:0] n);
		return f.msb ? 4'(f.nbits - 4'h1 - n) : n;
	endfunction : asr_idx

	function automatic logic asr_par(input logic [8:0] d, input asr_fmt_t f);
		logic [8:0] m;
		m = (f.nbits == `ASR_LEN7) ? 9'h07F : (f.nbits == `ASR_LEN8) ? 9'h0FF : 9'h1FF;
		return (^(d & m)) ^ f.par_odd;
	endfunction : asr_par
endpackage : asr_pkg
`default_nettype wire

// >>> asr_baud.sv
// baud tick generator: count source select and programmable divider
`include "asr_cfg.svh"
`default_nettype none
module asr_baud
	import asr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic div8_i,
	input wire logic [7:0] div_i,
	output logic tick16_o
);
	logic [2:0] pre_q;
	logic [7:0] cnt_q;
	logic src_en;

	// prescaler runs free so the divide-by-eight source needs no restart
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_q <= 3'h0;
		end else begin
			pre_q <= 3'(pre_q + 3'h1);
		end
	end

	assign src_en = div8_i ? (pre_q == `ASR_PRE_LAST) : 1'b1;

	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			cnt_q <= `ASR_BAUD_RST;
			tick16_o <= 1'b0;
		end else if (src_en && cnt_q == 8'h00) begin
			cnt_q <= div_i;
			tick16_o <= 1'b1;
		end else begin
			cnt_q <= src_en ? 8'(cnt_q - 8'h01) : cnt_q;
			tick16_o <= 1'b0;
		end
	end
endmodule : asr_baud
`default_nettype wire

// >>> asr_irq.sv
// sticky event status, mask and level interrupt
`include "asr_cfg.svh"
`default_nettype none
module asr_irq
	import asr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [`ASR_ST_W-1:0] ev_i,
	input wire logic clr_we_i,
	input wire logic mask_we_i,
	input wire logic [`ASR_ST_W-1:0] wdat_i,
	output logic [`ASR_ST_W-1:0] stat_o,
	output logic [`ASR_ST_W-1:0] mask_o,
	output logic irq_o
);
	logic [`ASR_ST_W-1:0] stat_d;

	// an event in the clearing cycle survives: set wins
	always_comb begin
		stat_d = stat_o;
		if (clr_we_i) begin
			stat_d = stat_d & ~wdat_i;
		end
		stat_d = stat_d | ev_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_o <= '0;
		end else begin
			stat_o <= stat_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_o <= '0;
		end else if (mask_we_i) begin
			mask_o <= wdat_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(stat_d & (mask_we_i ? wdat_i : mask_o));
		end
	end
endmodule : asr_irq
`default_nettype wire

// >>> asr_top_asserts.sv
// port-level assertions for the serial rate and format block
`include "asr_cfg.svh"
`default_nettype none
module asr_top_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	input wire logic serial_out_pin_o,
	input wire logic serial_out_pin_oe_o,
	input wire logic irq_o
);
	logic [7:0] baud_q;
	logic [7:0] adr_q;
	logic [15:0] run_q;
	logic [1:0] offn_q;
	logic div8_q, od_q, off_q, rd_q;
	wire logic tk = cyc_i && stb_i && !ack_o;
	wire logic wr = tk && we_i && sel_i[0];
	// shadow of the divider so bit length is known from bus traffic alone
	wire logic [15:0] bitlen = ({8'h00, baud_q} + 16'h0001) << (div8_q ? 7 : 4);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			baud_q <= 8'h00;
			div8_q <= 1'b0;
			od_q <= 1'b0;
			off_q <= 1'b1;
		end else if (wr && adr_i == `ASR_OFS_BAUD) begin
			baud_q <= dat_i[7:0];
		end else if (wr && adr_i == `ASR_OFS_CTLA) begin
			div8_q <= dat_i[0];
			od_q <= dat_i[3];
		end else if (wr && adr_i == `ASR_OFS_MODE) begin
			off_q <= dat_i[2:0] != 3'h1 && dat_i[2:0] != 3'h5 && dat_i[2:0] != 3'h6;
		end
	end
	always_ff @(posedge clk_i) begin
		rd_q <= tk && !we_i;
		adr_q <= adr_i;
		run_q <= (rst_i || serial_out_pin_o) ? 16'h0000 : run_q + 16'h0001;
		offn_q <= (rst_i || !off_q) ? 2'h0 : (offn_q == 2'h2) ? offn_q : offn_q + 2'h1;
	end
	a_ack_next: assert property (tk |=> ack_o)
		else $error("no ack one cycle after request");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack held too long");
	a_reset_quiet: assert property (@(posedge clk_i) disable iff (1'b0)
		rst_i |=> serial_out_pin_o && !ack_o && !irq_o) else $error("not idle in reset");
	a_bit_length: assert property ($rose(serial_out_pin_o) |-> run_q % bitlen == 16'h0000)
		else $error("low run not a whole number of bits");
	a_push_pull: assert property (!od_q && !$past(od_q) |-> serial_out_pin_oe_o)
		else $error("push-pull output not driven");
	a_drain_float: assert property (od_q && $past(od_q) |-> !(serial_out_pin_oe_o && serial_out_pin_o))
		else $error("open drain drives high");
	a_unmapped_zero: assert property (ack_o && rd_q && adr_q > 8'h20 |-> dat_o == 32'h00000000)
		else $error("unmapped read not zero");
	a_read_upper: assert property (ack_o && rd_q |-> dat_o[31:9] == 23'h000000)
		else $error("upper read bits not zero");
	a_off_idle: assert property (offn_q == 2'h2 |-> serial_out_pin_o)
		else $error("line low while mode off");
	c_start: cover property ($fell(serial_out_pin_o));
	c_irq: cover property ($rose(irq_o));
	c_drain: cover property (od_q && serial_out_pin_oe_o);
endmodule : asr_top_chk
bind asr_top asr_top_chk chk_u (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i,
	.stb_i, .ack_o, .serial_out_pin_o, .serial_out_pin_oe_o, .irq_o);
`default_nettype wire

// >>> asr_remote.sv
// remote asynchronous transceiver model on the serial line
`default_nettype none
module asr_remote (
	input wire logic clk_i,
	input wire logic line_i,
	input wire logic [15:0] bitlen_i,
	input wire logic [3:0] nb_i,
	input wire logic send_i,
	input wire logic [11:0] pat_i,
	output logic line_o,
	output logic busy_o,
	output logic [11:0] got_o,
	output logic done_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		line_o = 1'b1;
		busy_o = 1'b0;
		got_o = 12'h000;
		done_o = 1'b0;
	end
	// line bits go out first bit first, each a full bit time; idle high
	always @(posedge clk_i) begin
		if (send_i) begin
			busy_o <= 1'b1;
			for (int i = 0; i < nb_i; i++) begin
				line_o <= pat_i[i];
				repeat (bitlen_i) @(posedge clk_i);
			end
			line_o <= 1'b1;
			busy_o <= 1'b0;
		end
	end
	// mid-bit sampling, so a short or shifted bit reads wrong
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		if (!line_i) begin
			got_o <= 12'h000;
			repeat (bitlen_i / 2 - 1) @(posedge clk_i);
			for (int i = 0; i < nb_i; i++) begin
				got_o[i] <= line_i;
				repeat (bitlen_i) @(posedge clk_i);
			end
			done_o <= 1'b1;
		end
	end
endmodule : asr_remote
`default_nettype wire

// >>> tb_async_serial_rate_and_format.sv
// self-checking bench for the serial rate and format block
`include "asr_cfg.svh"
`default_nettype none
module tb_async_serial_rate_and_format;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [5:0] mode;
		logic [3:0] ctla;
		logic [7:0] baud;
		logic [8:0] data;
		logic [11:0] pat;
		logic [3:0] nb;
		logic [8:0] mask;
	} asr_row_t;
	asr_row_t rows [6] = '{'{6'h05, 4'h0, 8'h00, 9'h035, 12'h26A, 4'hA, 9'h0FF},
		'{6'h15, 4'h4, 8'h00, 9'h035, 12'h558, 4'hB, 9'h0FF},
		'{6'h39, 4'h4, 8'h00, 9'h035, 12'h76A, 4'hB, 9'h07F},
		'{6'h06, 4'h1, 8'h01, 9'h1A5, 12'h74A, 4'hB, 9'h1FF},
		'{6'h05, 4'h2, 8'h02, 9'h0C3, 12'h386, 4'hA, 9'h0FF},
		'{6'h05, 4'h8, 8'h00, 9'h00F, 12'h21E, 4'hA, 9'h0FF}};
	logic [2:0] enc [3] = '{`ASR_SMD_U7, `ASR_SMD_U8, `ASR_SMD_U9};
	logic [11:0] epat [3] = '{12'h1AA, 12'h2AA, 12'h4AA};
	logic [3:0] enb [3] = '{4'h9, 4'hA, 4'hB};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, ack_o, out, oe, irq_o, rx_line, line;
	logic send = 1'b0, busy, done;
	logic [15:0] bitlen = 16'h0010;
	logic [3:0] nb = 4'hA;
	logic [11:0] pat = 12'hFFF, got;
	int fails = 0, compares = 0;
	asr_top dut_u (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i(4'hF), .cyc_i, .stb_i,
		.ack_o, .serial_in_pin_i(rx_line), .serial_out_pin_o(out), .serial_out_pin_oe_o(oe), .irq_o);
	asr_remote far_u (.clk_i, .line_i(line), .bitlen_i(bitlen), .nb_i(nb), .send_i(send),
		.pat_i(pat), .line_o(rx_line), .busy_o(busy), .got_o(got), .done_o(done));
	// pull-up on the line when nobody drives it
	assign line = oe ? out : 1'b1;
	initial forever #20 clk_i = ~clk_i;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		// ack and read data are taken at the rising edge, then released there
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		chk(n < 20, 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : wb
	task automatic await(ref logic s, input logic v);
		int n;
		n = 0;
		while (s !== v && n < 9000) begin
			n++;
			@(negedge clk_i);
		end
		chk(n < 9000, 1'b1);
	endtask : await
	task automatic send_frame(input logic [11:0] p);
		@(posedge clk_i);
		send <= 1'b1;
		pat <= p;
		@(posedge clk_i);
		send <= 1'b0;
		await(busy, 1'b1);
		await(busy, 1'b0);
	endtask : send_frame
	task automatic end_sim();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim
	initial begin
		repeat (30000) @(posedge clk_i);
		fails++;
		end_sim();
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, `ASR_OFS_BAUD, 0);
		chk(rd, `ASR_BAUD_RST);
		wb(1, 8'h3C, 32'h5);
		wb(0, 8'h3C, 0);
		chk(rd, 0);
		chk(line, 1'b1);
		$display("reset test done");
		foreach (rows[i]) begin
			bitlen <= ({8'h00, rows[i].baud} + 16'h0001) << (rows[i].ctla[0] ? 7 : 4);
			nb <= rows[i].nb;
			wb(1, `ASR_OFS_MODE, rows[i].mode);
			wb(1, `ASR_OFS_CTLA, rows[i].ctla);
			wb(1, `ASR_OFS_BAUD, rows[i].baud);
			wb(1, `ASR_OFS_MASK, 32'h4);
			wb(1, `ASR_OFS_CTLB, 32'h3);
			wb(1, `ASR_OFS_TXB, rows[i].data);
			await(done, 1'b1);
			chk(got, rows[i].pat);
			send_frame(rows[i].pat);
			wb(0, `ASR_OFS_RXB, 0);
			chk(rd & rows[i].mask, rows[i].data);
			chk(irq_o, 1'b1);
			wb(0, `ASR_OFS_STAT, 0);
			chk(rd, 32'h7);
			wb(1, `ASR_OFS_STAT, 32'h3F);
			chk(irq_o, 1'b0);
			$display("row %0d done", i);
		end
		// receive clear: drop and restore rx_on with a frame held
		wb(1, `ASR_OFS_CTLA, 0);
		wb(1, `ASR_OFS_MASK, 0);
		send_frame(12'h26A);
		chk(irq_o, 1'b0);
		wb(1, `ASR_OFS_CTLB, 32'h1);
		wb(1, `ASR_OFS_CTLB, 32'h3);
		wb(0, `ASR_OFS_STATE, 0);
		chk(rd[2], 1'b0);
		wb(0, `ASR_OFS_RXB, 0);
		chk(rd, 0);
		$display("receive clear test done");
		// transmit clear: a pending byte is dropped by mode off
		wb(1, `ASR_OFS_CTLB, 0);
		wb(1, `ASR_OFS_TXB, 32'h55);
		foreach (enc[i]) begin
			nb <= enb[i];
			wb(1, `ASR_OFS_MODE, 0);
			wb(0, `ASR_OFS_STATE, 0);
			chk(rd[4:0], 5'h10);
			wb(1, `ASR_OFS_MODE, enc[i]);
			wb(1, `ASR_OFS_TXB, 32'h55);
			wb(0, `ASR_OFS_STATE, 0);
			chk(rd[4:0], 5'h12);
			chk(line, 1'b1);
			wb(1, `ASR_OFS_CTLB, 32'h1);
			await(done, 1'b1);
			chk(got, epat[i]);
		end
		$display("transmit clear test done");
		end_sim();
	end
endmodule : tb_async_serial_rate_and_format
`default_nettype wire
